// File: rtl/prs_pkg.sv
// Package: constants and carriers for the pixel readout sequencer
package prs_pkg;

  // ==========================================================
  // Array geometry
  localparam int unsigned ARRAY_COLS = 640;
  localparam int unsigned ARRAY_ROWS = 480;
  localparam int unsigned COL_W = 10;
  localparam int unsigned ROW_W = 9;
  localparam int unsigned X_STEP = 8;
  localparam int unsigned KERNEL = 4;
  localparam int unsigned PIX_W = 10;
  localparam int unsigned OFS_W = 8;

  // ==========================================================
  // Overhead periods in master clock periods
  localparam logic [10:0] FOT_G3 = 11'd1200;
  localparam logic [10:0] FOT_G2 = 11'd624;
  localparam logic [10:0] FOT_G1 = 11'd336;
  localparam logic [10:0] FOT_G0 = 11'd192;
  localparam logic [10:0] ROT_G3 = 11'd48;
  localparam logic [10:0] ROT_G2 = 11'd32;
  localparam logic [10:0] ROT_G1 = 11'd24;
  localparam logic [10:0] ROT_G0 = 11'd20;
  localparam logic [10:0] ROT_SUB_EXTRA = 11'd8;
  localparam int unsigned OVH_W = 11;

  // ==========================================================
  // Converter latency: result at the 6th falling edge, i.e. 6 sample slots
  localparam int unsigned ADC_LAT_SLOTS = 6;
  localparam int unsigned PIPE_LEN = ADC_LAT_SLOTS * KERNEL;

  // Default offset pair giving the nominal offset step
  localparam logic [7:0] OFS_REF_RST = 8'hC8;
  localparam logic [7:0] BLK_REF_RST = 8'h00;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [COL_W-1:0] x_start;
    logic [COL_W-1:0] width;
    logic [ROW_W-1:0] y_start;
    logic [ROW_W-1:0] lines;
    logic [1:0] readout_granularity;
    logic subsample;
  } prs_geom_s;

  typedef struct packed {
    logic valid;
    logic sof;
    logic sol;
    logic [PIX_W-1:0] data;
  } prs_pix_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FOT = 2'b01,
    ST_ROT = 2'b10,
    ST_PIX = 2'b11
  } prs_state_e;

endpackage : prs_pkg

// File: rtl/prs_sequencer.sv
// Design: readout timing, windowing and converter multiplexing
//
// What this block does
// - Progressive 640x480 scan, line after line
// - Column window snaps to multiples of eight
// - Start column and row are loadable
// - Row step one, or two when subsampling
// - Width from count, lines from line timer
// - Four adjacent columns selected per group
// - Four converters interleaved, one pixel per clock
// - Frame equals overhead plus rows of pixels
// - Frame overhead 1200/624/336/192 by granularity
// - Row overhead 48/32/24/20 by granularity
// - Subsampling lengthens row overhead by eight
// - Every converter result is ten bits
// - Result appears six sample slots later
// - Offset equals offset minus black reference
// - Default offset fields give nominal offset
// - Subsampling reads one row, skips next
`timescale 1ns/100ps
`default_nettype none

module prs_sequencer #(
  parameter int unsigned LAT = prs_pkg::PIPE_LEN
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Configuration
  input wire logic run_i,
  input wire prs_pkg::prs_geom_s geom_i,
  input wire logic [prs_pkg::OFS_W-1:0] offset_reference_level_i,
  input wire logic [prs_pkg::OFS_W-1:0] black_reference_level_i,
  input wire logic ofs_load_i,
  // Converter side
  input wire logic [prs_pkg::KERNEL*prs_pkg::PIX_W-1:0] adc_data_i,
  output logic [prs_pkg::COL_W-1:0] sel_col_o,
  output logic [prs_pkg::ROW_W-1:0] sel_row_o,
  output logic [prs_pkg::KERNEL-1:0] adc_sample_o,
  output logic signed [prs_pkg::OFS_W:0] offset_step_o,
  // Pixel bus
  output prs_pkg::prs_pix_s pix_o,
  output logic busy_o
);

  localparam int unsigned CW = prs_pkg::COL_W;
  localparam int unsigned RW = prs_pkg::ROW_W;
  localparam int unsigned OW = prs_pkg::OVH_W;
  localparam int unsigned PW = prs_pkg::PIX_W;
  localparam int unsigned K = prs_pkg::KERNEL;
  // Row steps; subsampling reads one row and skips the next
  localparam logic [RW-1:0] ROW_STEP_FULL = RW'(1);
  localparam logic [RW-1:0] ROW_STEP_SUB = RW'(2);

  // ==========================================================
  // Sequencer state
  prs_pkg::prs_state_e state_ff, nxt_state;
  prs_pkg::prs_geom_s geom_ff, nxt_geom;
  logic [OW-1:0] ovh_cnt_ff, nxt_ovh_cnt;
  logic [CW-1:0] col_ff, nxt_col;
  logic [CW-1:0] pix_cnt_ff, nxt_pix_cnt;
  logic [RW-1:0] row_ff, nxt_row;
  logic [RW-1:0] line_cnt_ff, nxt_line_cnt;
  logic [1:0] slot_ff, nxt_slot;

  // ==========================================================
  // Overhead tables
  function automatic logic [OW-1:0] fot_of(input logic [1:0] g);
    case (g)
      2'b11: fot_of = prs_pkg::FOT_G3;
      2'b10: fot_of = prs_pkg::FOT_G2;
      2'b01: fot_of = prs_pkg::FOT_G1;
      default: fot_of = prs_pkg::FOT_G0;
    endcase
  endfunction

  function automatic logic [OW-1:0] rot_of(input logic [1:0] g, input logic sub);
    logic [OW-1:0] r;
    case (g)
      2'b11: r = prs_pkg::ROT_G3;
      2'b10: r = prs_pkg::ROT_G2;
      2'b01: r = prs_pkg::ROT_G1;
      default: r = prs_pkg::ROT_G0;
    endcase
    rot_of = sub ? r + prs_pkg::ROT_SUB_EXTRA : r;
  endfunction

  // ==========================================================
  // Window sanitising: column fields forced to multiples of eight
  prs_pkg::prs_geom_s geom_in;
  always_comb begin
    geom_in = geom_i;
    geom_in.x_start[2:0] = 3'h0;
    geom_in.width[2:0] = 3'h0;
    if (geom_in.width == '0 || geom_in.width > CW'(prs_pkg::ARRAY_COLS)) begin
      geom_in.width = CW'(prs_pkg::ARRAY_COLS);
    end
    if (geom_in.lines == '0 || geom_in.lines > RW'(prs_pkg::ARRAY_ROWS)) begin
      geom_in.lines = RW'(prs_pkg::ARRAY_ROWS);
    end
  end

  // ==========================================================
  // Window end detection
  logic last_pix;
  logic last_line;
  logic [RW-1:0] row_step;
  assign last_pix = (pix_cnt_ff == geom_ff.width - CW'(1));
  assign last_line = (line_cnt_ff == geom_ff.lines - RW'(1));
  // No wrap: start row plus lines times step must stay inside the array
  assign row_step = geom_ff.subsample ? ROW_STEP_SUB : ROW_STEP_FULL;

  always_comb begin
    nxt_state = state_ff;
    nxt_geom = geom_ff;
    nxt_ovh_cnt = ovh_cnt_ff;
    nxt_col = col_ff;
    nxt_pix_cnt = pix_cnt_ff;
    nxt_row = row_ff;
    nxt_line_cnt = line_cnt_ff;
    nxt_slot = slot_ff;
    case (state_ff)
      prs_pkg::ST_IDLE: begin
        if (run_i) begin
          nxt_geom = geom_in;
          nxt_ovh_cnt = fot_of(geom_in.readout_granularity) - OW'(1);
          nxt_state = prs_pkg::ST_FOT;
        end
      end
      prs_pkg::ST_FOT: begin
        if (ovh_cnt_ff == '0) begin
          nxt_row = geom_ff.y_start;
          nxt_line_cnt = '0;
          nxt_ovh_cnt = rot_of(geom_ff.readout_granularity, geom_ff.subsample) - OW'(1);
          nxt_state = prs_pkg::ST_ROT;
        end else begin
          nxt_ovh_cnt = ovh_cnt_ff - OW'(1);
        end
      end
      prs_pkg::ST_ROT: begin
        if (ovh_cnt_ff == '0) begin
          nxt_col = geom_ff.x_start;
          nxt_pix_cnt = '0;
          nxt_slot = '0;
          nxt_state = prs_pkg::ST_PIX;
        end else begin
          nxt_ovh_cnt = ovh_cnt_ff - OW'(1);
        end
      end
      prs_pkg::ST_PIX: begin
        nxt_pix_cnt = pix_cnt_ff + CW'(1);
        nxt_slot = slot_ff + 2'h1;
        if (slot_ff == 2'(K - 1)) begin
          nxt_col = col_ff + CW'(K);
        end
        if (last_pix) begin
          if (last_line) begin
            nxt_state = prs_pkg::ST_IDLE;
          end else begin
            nxt_row = row_ff + row_step;
            nxt_line_cnt = line_cnt_ff + RW'(1);
            nxt_ovh_cnt = rot_of(geom_ff.readout_granularity, geom_ff.subsample) - OW'(1);
            nxt_state = prs_pkg::ST_ROT;
          end
        end
      end
      default: nxt_state = prs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= prs_pkg::ST_IDLE;
      geom_ff <= '0;
      ovh_cnt_ff <= '0;
      col_ff <= '0;
      pix_cnt_ff <= '0;
      row_ff <= '0;
      line_cnt_ff <= '0;
      slot_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      geom_ff <= nxt_geom;
      ovh_cnt_ff <= nxt_ovh_cnt;
      col_ff <= nxt_col;
      pix_cnt_ff <= nxt_pix_cnt;
      row_ff <= nxt_row;
      line_cnt_ff <= nxt_line_cnt;
      slot_ff <= nxt_slot;
    end
  end

  // ==========================================================
  // Sample strobes, one converter per slot: each runs at a quarter rate
  logic [K-1:0] nxt_sample;
  logic [PW-1:0] lane_data [K];
  logic sol_mark;
  logic sof_mark;
  assign sol_mark = (state_ff == prs_pkg::ST_PIX) && (pix_cnt_ff == '0);
  assign sof_mark = sol_mark && (line_cnt_ff == '0);

  genvar gi;
  generate
    for (gi = 0; gi < K; gi++) begin : g_strobe
      assign nxt_sample[gi] = (state_ff == prs_pkg::ST_PIX) && (slot_ff == 2'(gi));
      assign lane_data[gi] = adc_data_i[gi*PW +: PW];
    end
  endgenerate

  // ==========================================================
  // Converter pipeline: tag tracks each sample until its result is due
  // Depth fixes the latency; a slower converter needs a larger LAT
  logic [LAT-1:0] vld_pipe_ff, nxt_vld_pipe;
  logic [LAT-1:0] sol_pipe_ff, nxt_sol_pipe;
  logic [LAT-1:0] sof_pipe_ff, nxt_sof_pipe;
  logic [2*LAT-1:0] slot_pipe_ff, nxt_slot_pipe;
  logic [1:0] out_slot;

  always_comb begin
    nxt_vld_pipe = {vld_pipe_ff[LAT-2:0], state_ff == prs_pkg::ST_PIX};
    nxt_sol_pipe = {sol_pipe_ff[LAT-2:0], sol_mark};
    nxt_sof_pipe = {sof_pipe_ff[LAT-2:0], sof_mark};
    nxt_slot_pipe = {slot_pipe_ff[2*LAT-3:0], slot_ff};
  end

  assign out_slot = slot_pipe_ff[2*LAT-1 -: 2];

  // ==========================================================
  // Output mux, one converter lane per clock
  prs_pkg::prs_pix_s nxt_pix;
  always_comb begin
    nxt_pix.valid = vld_pipe_ff[LAT-1];
    nxt_pix.sol = sol_pipe_ff[LAT-1];
    nxt_pix.sof = sof_pipe_ff[LAT-1];
    nxt_pix.data = vld_pipe_ff[LAT-1] ? lane_data[out_slot] : '0;
  end

  // ==========================================================
  // Offset: the difference of the two reference codes, signed
  logic [prs_pkg::OFS_W-1:0] ofs_ref_ff, nxt_ofs_ref;
  logic [prs_pkg::OFS_W-1:0] blk_ref_ff, nxt_blk_ref;
  logic signed [prs_pkg::OFS_W:0] nxt_offset_step;
  always_comb begin
    nxt_ofs_ref = ofs_load_i ? offset_reference_level_i : ofs_ref_ff;
    nxt_blk_ref = ofs_load_i ? black_reference_level_i : blk_ref_ff;
    nxt_offset_step = $signed({1'b0, ofs_ref_ff}) - $signed({1'b0, blk_ref_ff});
  end

  // Codes reload at any time; the step follows one clock behind them
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ofs_ref_ff <= prs_pkg::OFS_REF_RST;
      blk_ref_ff <= prs_pkg::BLK_REF_RST;
      offset_step_o <= '0;
    end else begin
      ofs_ref_ff <= nxt_ofs_ref;
      blk_ref_ff <= nxt_blk_ref;
      offset_step_o <= nxt_offset_step;
    end
  end

  // ==========================================================
  // Output registers, straight to the ports
  logic [CW-1:0] nxt_sel_col;
  logic [RW-1:0] nxt_sel_row;
  logic nxt_busy;
  always_comb begin
    nxt_sel_col = col_ff;
    nxt_sel_row = row_ff;
    nxt_busy = (nxt_state != prs_pkg::ST_IDLE);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      vld_pipe_ff <= '0;
      sol_pipe_ff <= '0;
      sof_pipe_ff <= '0;
      slot_pipe_ff <= '0;
      pix_o <= '0;
      sel_col_o <= '0;
      sel_row_o <= '0;
      adc_sample_o <= '0;
      busy_o <= 1'b0;
    end else begin
      vld_pipe_ff <= nxt_vld_pipe;
      sol_pipe_ff <= nxt_sol_pipe;
      sof_pipe_ff <= nxt_sof_pipe;
      slot_pipe_ff <= nxt_slot_pipe;
      pix_o <= nxt_pix;
      sel_col_o <= nxt_sel_col;
      sel_row_o <= nxt_sel_row;
      adc_sample_o <= nxt_sample;
      busy_o <= nxt_busy;
    end
  end

endmodule // prs_sequencer

`default_nettype wire

// File: test/prs_capture_model.sv
// Partner: capture controller counting pixels and lines
`timescale 1ns/100ps
`default_nettype none
module prs_capture_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Pixel bus
  input wire prs_pkg::prs_pix_s pix_i,
  // Counts
  output logic [10:0] line_px_o,
  output logic [9:0] lines_o
);
  // ====
  // Overhead cycles carry no pixel, so only valid is counted
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      line_px_o <= '0;
      lines_o <= '0;
    end else if (pix_i.valid) begin
      line_px_o <= pix_i.sol ? 11'h001 : line_px_o + 11'h001;
      lines_o <= pix_i.sof ? 10'h001 : lines_o + {9'h000, pix_i.sol};
    end
  end
endmodule // prs_capture_model
`default_nettype wire

// File: test/prs_sequencer_checker.sv
// Checker: readout order, lane and offset properties
`timescale 1ns/100ps
`default_nettype none
module prs_sequencer_checker #(
  parameter int unsigned LAT = prs_pkg::PIPE_LEN
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Watched ports
  input wire prs_pkg::prs_geom_s geom_i,
  input wire logic [7:0] offset_reference_level_i,
  input wire logic [7:0] black_reference_level_i,
  input wire logic ofs_load_i,
  input wire logic [9:0] sel_col_o,
  input wire logic [8:0] sel_row_o,
  input wire logic [3:0] adc_sample_o,
  input wire logic signed [8:0] offset_step_o,
  input wire prs_pkg::prs_pix_s pix_o,
  input wire logic busy_o
);
  localparam int D = LAT;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // ====
  // Properties
  property p_sof; pix_o.sof |-> pix_o.sol && pix_o.valid; endproperty
  a_sof: assert property (p_sof) else $error("sof alone");
  property p_start; $rose(pix_o.valid) |-> pix_o.sol; endproperty
  a_start: assert property (p_start) else $error("line start");
  property p_gap; $fell(pix_o.valid) |-> !pix_o.valid [*8]; endproperty
  a_gap: assert property (p_gap) else $error("short gap");
  property p_hot; $onehot0(adc_sample_o); endproperty
  a_hot: assert property (p_hot) else $error("lanes");
  property p_lane; adc_sample_o[0] |=> adc_sample_o[1] ##1 adc_sample_o[2] ##1 adc_sample_o[3]; endproperty
  a_lane: assert property (p_lane) else $error("lane order");
  property p_col; adc_sample_o[3] ##1 adc_sample_o[0] |-> sel_col_o == $past(sel_col_o) + 10'h004; endproperty
  a_col: assert property (p_col) else $error("col step");
  property p_row;
    adc_sample_o[3] ##1 $changed(sel_row_o)
      |-> sel_row_o == $past(sel_row_o) + (geom_i.subsample ? 9'h002 : 9'h001);
  endproperty
  a_row: assert property (p_row) else $error("row step");
  property p_lat; |adc_sample_o |-> ##D pix_o.valid; endproperty
  a_lat: assert property (p_lat) else $error("latency");
  property p_ofs;
    ofs_load_i ##2 1'b1 |-> offset_step_o == $signed({1'b0, $past(offset_reference_level_i, 2)})
      - $signed({1'b0, $past(black_reference_level_i, 2)});
  endproperty
  a_ofs: assert property (p_ofs) else $error("offset");
endmodule // prs_sequencer_checker
bind prs_sequencer prs_sequencer_checker #(.LAT(LAT)) u_prs_sequencer_checker (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .geom_i(geom_i), .ofs_load_i(ofs_load_i),
  .offset_reference_level_i(offset_reference_level_i), .black_reference_level_i(black_reference_level_i),
  .sel_col_o(sel_col_o), .sel_row_o(sel_row_o), .adc_sample_o(adc_sample_o),
  .offset_step_o(offset_step_o), .pix_o(pix_o), .busy_o(busy_o));
`default_nettype wire

// File: test/prs_sequencer_test.sv
// Bench: frame timing, window and offset tests
`timescale 1ns/100ps
`default_nettype none
module prs_sequencer_test;
  localparam int unsigned LAT = prs_pkg::PIPE_LEN;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic run_i = 1'b0;
  logic ld = 1'b0;
  logic [7:0] ofr = 8'h00;
  logic [7:0] blk = 8'h00;
  prs_pkg::prs_geom_s geom = '0;
  logic [39:0] adc = {10'h001, 10'h3FF, 10'h155, 10'h2AA};
  logic [9:0] col;
  logic [8:0] row;
  logic [3:0] smp;
  logic signed [8:0] ofs_o;
  prs_pkg::prs_pix_s pix;
  logic busy;
  logic [10:0] lpx;
  logic [9:0] lns;
  int errors = 0;
  int cmp_count = 0;
  int frame_overhead_time[4] = '{192, 336, 624, 1200};
  int row_overhead_time[4] = '{20, 24, 32, 48};
  always #10 sys_clk_i = ~sys_clk_i;
  prs_sequencer #(.LAT(LAT)) u_prs_sequencer (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .run_i(run_i),
    .geom_i(geom), .offset_reference_level_i(ofr), .black_reference_level_i(blk), .ofs_load_i(ld),
    .adc_data_i(adc), .sel_col_o(col), .sel_row_o(row), .adc_sample_o(smp), .offset_step_o(ofs_o),
    .pix_o(pix), .busy_o(busy));
  prs_capture_model u_prs_capture_model (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .pix_i(pix),
    .line_px_o(lpx), .lines_o(lns));
  // ====
  // Tasks
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    cmp_count++;
    if (a !== e) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask
  task automatic close_out;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic ofs(input logic [7:0] o, input logic [7:0] b);
    ofr = o;
    blk = b;
    ld = 1'b1;
    @(negedge sys_clk_i);
    ld = 1'b0;
    repeat (3) @(negedge sys_clk_i);
  endtask
  // Three lines from row 2, column 8; chg widens the geom input mid-frame, and the frame keeps its latched width
  task automatic frame(input logic [1:0] g, input logic s, input logic [9:0] w, input int ew, input logic chg);
    int px = 0;
    int ls = 0;
    int bz = 0;
    int f = 1;
    geom = '{10'h008, w, 9'h002, 9'h003, g, s};
    run_i = 1'b1;
    @(negedge sys_clk_i);
    run_i = 1'b0;
    for (int t = 0; t < frame_overhead_time[g] + 3 * (row_overhead_time[g] + ew + 8) + 60; t++) begin
      if (chg && t == 9) geom.width = 10'h020;
      bz += int'(busy);
      if (smp[0] && f == 1) begin
        f = 0;
        chk({22'h0, col}, 32'h8);
        chk({23'h0, row}, 32'h2);
      end
      if (pix.sol) begin
        if (ls == 0) chk(t, frame_overhead_time[g] + row_overhead_time[g] + 8 * s + LAT + 1);
        else chk(t - ls, row_overhead_time[g] + 8 * s + ew);
        if (ls != 0) chk({21'h0, lpx}, ew);
        ls = t;
        px = 0;
      end
      if (pix.valid) chk({22'h0, pix.data}, {22'h0, adc[(px % 4) * 10 +: 10]});
      px += int'(pix.valid);
      @(negedge sys_clk_i);
    end
    chk(bz, frame_overhead_time[g] + 3 * (row_overhead_time[g] + 8 * s + ew));
    chk({21'h0, lpx}, ew);
    chk({22'h0, lns}, 3);
  endtask
  // ====
  // Tests
  initial begin
    repeat (5) @(negedge sys_clk_i);
    rst_i = 1'b0;
    @(negedge sys_clk_i);
    chk(32'(ofs_o), 32'd200);
    ofs(8'h50, 8'h10);
    chk(32'(ofs_o), 32'h40);
    ofs(8'h10, 8'h50);
    chk(32'(ofs_o), 32'hFFFFFFC0);
    for (int g = 0; g < 4; g++) frame(2'(g), 1'b0, 10'h010, 16, 1'b0);
    frame(2'h2, 1'b1, 10'h015, 16, 1'b0);
    frame(2'h0, 1'b0, 10'h010, 16, 1'b1);
    close_out();
  end
  initial begin
    #400000;
    errors++;
    close_out();
  end
endmodule // prs_sequencer_test
`default_nettype wire
